// [verilog/serial_port_pkg.sv]
`default_nettype none
package serial_port_pkg;

  // Register indices; the bus byte address is four times the index
  localparam logic [7:0] IDX_RATE_CTRL  = 8'h87;
  localparam logic [7:0] IDX_SERIAL_CTL = 8'h98;
  localparam logic [7:0] IDX_SERIAL_BUF = 8'h99;
  localparam logic [7:0] IDX_CONFIG     = 8'hAF;
  localparam logic [7:0] IDX_SERIAL_CTL2 = 8'hE1;
  localparam int         ADDR_W         = 10;

  // serial_control fields
  localparam int CTL_RECEIVE_DONE  = 0;
  localparam int CTL_TRANSMIT_DONE = 1;
  localparam int CTL_RX_NINTH      = 2;
  localparam int CTL_TX_NINTH      = 3;
  localparam int CTL_RX_ENABLE     = 4;
  localparam int CTL_FILTER        = 5;
  localparam int CTL_MODE_LO       = 6;
  localparam int CTL_MODE_HI       = 7;
  // Other fields
  localparam int RATE_DOUBLE_BIT   = 7;
  localparam int EXT_RX_ENABLE_BIT = 6;
  localparam int OVERWRITE_BIT     = 5;

  // Reset values
  localparam logic [7:0] RESET_RATE_CTRL  = 8'h00;
  localparam logic [7:0] RESET_SERIAL_CTL = 8'h00;
  localparam logic [7:0] RESET_SERIAL_BUF = 8'h00;
  localparam logic [7:0] RESET_CONFIG     = 8'h00;

  // Timing counts in core clocks or rate ticks
  localparam int SHIFT_MODE_DIV  = 12;
  localparam int SHIFT_MODE_HALF = SHIFT_MODE_DIV / 2;
  localparam int OVERSAMPLE      = 16;
  localparam int FIXED_DIV_SLOW  = 64;
  localparam int FIXED_DIV_FAST  = 32;
  localparam int START_CHECK     = OVERSAMPLE / 2 - 1;

  // Frame lengths in bit ticks; transmit lengths count one extra tick that ends the last bit
  localparam logic [3:0] TX_LEN_SHIFT = 4'h9;
  localparam logic [3:0] TX_LEN_8BIT  = 4'hB;
  localparam logic [3:0] TX_LEN_9BIT  = 4'hC;
  localparam logic [3:0] RX_LEN_ASYNC = 4'h9;
  localparam logic [3:0] RX_LEN_SHIFT = 4'h8;

  typedef enum logic [1:0] {MODE_SHIFT, MODE_8BIT, MODE_9BIT_FIXED, MODE_9BIT_VAR} mode_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_SHIFT0} rx_state_t;

endpackage : serial_port_pkg
`default_nettype wire

// [verilog/serial_port_four_mode_uart.sv]
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Two top control bits pick mode
// - Shift mode: data on receive pin, clock/12
// - Buffer write starts transmit, LSB first
// - Shift receive needs enable set, flag clear
// - 8-bit frame: start, eight data, stop
// - Variable rate from timer overflow ticks
// - 8-bit: stop in ninth slot, flag
// - Async receive starts on valid falling edge
// - Without extension, accept only flag clear
// - 8-bit filter needs stop bit high
// - Failed check drops frame, no flag
// - 8-bit accept: buffer, stop bit, flag
// - 9-bit frame: start, data, ninth, stop
// - Fixed 9-bit rate from core clock
// - 9-bit transmit ninth bit, flag on stop
// - 9-bit filter needs ninth bit high
// - 9-bit accept: buffer, ninth, flag
// - Mode 3 equals mode 2, timer rate
// - Extension overwrites, flags error, read clears
module serial_port_four_mode_uart (
  input  wire logic                               CLK,
  input  wire logic                               RESETN,
  input  wire logic                               PSEL,
  input  wire logic                               PENABLE,
  input  wire logic                               PWRITE,
  input  wire logic [serial_port_pkg::ADDR_W-1:0] PADDR,
  input  wire logic [31:0]                        PWDATA,
  output var  logic [31:0]                        PRDATA,
  output logic                                    PREADY,
  output logic                                    PSLVERR,
  input  wire logic                               TX_RATE_TICK,
  input  wire logic                               RX_RATE_TICK,
  input  wire logic                               RXD_IN,
  output var  logic                               RXD_OUT,
  output logic                                    RXD_OE,
  output logic                                    TXD
);

  function automatic logic reg_hit(input logic [serial_port_pkg::ADDR_W-1:0] addr, input logic [7:0] idx);
    reg_hit = (addr == {idx, 2'b00});
  endfunction : reg_hit

  // Register file and bus state
  logic [7:0] rate_ctrl;
  logic [7:0] ctl;
  logic [7:0] next_ctl;
  logic [7:0] cfg;
  logic [7:0] rx_buf;
  logic [7:0] tx_data;
  logic       overwrite;

  // Receive pin synchroniser and edge history
  logic       rx_meta;
  logic       rx_sync;
  logic       rx_prev;

  // Dividers: core_cnt and shift_div run free for the fixed rates; tx_sub counts timer ticks, os_cnt oversample ticks
  logic [5:0] core_cnt;
  logic [3:0] shift_div;
  logic [3:0] tx_sub;
  logic [3:0] os_cnt;

  // Transmit shifter; ones shift in behind the frame
  logic [10:0] tx_shift;
  logic [3:0] tx_left;
  logic       tx_busy;
  logic       tx_phase;
  logic       txd_line;

  // Receive shifter; the newest sample enters at the top
  logic [8:0] rx_shift;
  logic [3:0] rx_left;
  logic       rx_phase;
  serial_port_pkg::rx_state_t rx_state;

  // Bus decode
  wire        setup_cyc = PSEL & ~PENABLE;
  wire        access    = PSEL & PENABLE;
  wire        hit_rate  = reg_hit(PADDR, serial_port_pkg::IDX_RATE_CTRL);
  wire        hit_ctl   = reg_hit(PADDR, serial_port_pkg::IDX_SERIAL_CTL);
  wire        hit_buf   = reg_hit(PADDR, serial_port_pkg::IDX_SERIAL_BUF);
  wire        hit_cfg   = reg_hit(PADDR, serial_port_pkg::IDX_CONFIG);
  wire        hit_ctl2  = reg_hit(PADDR, serial_port_pkg::IDX_SERIAL_CTL2);
  wire        hit_any   = hit_rate | hit_ctl | hit_buf | hit_cfg | hit_ctl2;
  wire        wr_rate   = access & PWRITE & hit_rate;
  wire        wr_ctl    = access & PWRITE & hit_ctl;
  wire        wr_buf    = access & PWRITE & hit_buf;
  wire        wr_cfg    = access & PWRITE & hit_cfg;
  wire        rd_buf    = access & ~PWRITE & hit_buf;


  // Every register answers at once, so no wait states are inserted
  assign PREADY  = 1'b1;
  assign PSLVERR = access & ~hit_any;

  // Mode and option decode
  wire serial_port_pkg::mode_t mode = serial_port_pkg::mode_t'(ctl[serial_port_pkg::CTL_MODE_HI:serial_port_pkg::CTL_MODE_LO]);
  wire        is_shift    = (mode == serial_port_pkg::MODE_SHIFT);
  wire        is_fixed9   = (mode == serial_port_pkg::MODE_9BIT_FIXED);
  wire        is_8bit     = (mode == serial_port_pkg::MODE_8BIT);
  wire        rate_double = rate_ctrl[serial_port_pkg::RATE_DOUBLE_BIT];
  wire        ext_rx      = cfg[serial_port_pkg::EXT_RX_ENABLE_BIT];
  wire        rx_enable   = ctl[serial_port_pkg::CTL_RX_ENABLE];
  wire        filter      = ctl[serial_port_pkg::CTL_FILTER];
  wire        ri          = ctl[serial_port_pkg::CTL_RECEIVE_DONE];

  // Read data is captured in the setup cycle so the access phase needs no wait
  // Unmapped addresses read as zero
  wire [7:0]  rd_mux = hit_rate ? rate_ctrl :
                       hit_ctl  ? ctl :
                       hit_buf  ? rx_buf :
                       hit_cfg  ? cfg :
                       hit_ctl2 ? (8'h01 << serial_port_pkg::OVERWRITE_BIT) & {8{overwrite}} : 8'h00;

  // Bit timing
  // Mode 2 divides the core clock by a power of two, so a mask replaces a counter
  wire [5:0]  fixed_mask = rate_double ? 6'(serial_port_pkg::FIXED_DIV_FAST - 1)
                                       : 6'(serial_port_pkg::FIXED_DIV_SLOW - 1);
  wire [5:0]  os_mask    = fixed_mask >> 4;
  wire        shift_tick = (shift_div == 4'(serial_port_pkg::SHIFT_MODE_DIV - 1));
  wire        shift_rise = (shift_div == 4'(serial_port_pkg::SHIFT_MODE_HALF));
  // Mode 3 differs from mode 2 only in where the bit tick comes from
  wire        tx_tick    = is_shift  ? shift_tick :
                           is_fixed9 ? ((core_cnt & fixed_mask) == fixed_mask) :
                           (TX_RATE_TICK & (tx_sub == 4'(serial_port_pkg::OVERSAMPLE - 1)));
  wire        os_tick    = is_fixed9 ? ((core_cnt & os_mask) == os_mask) : RX_RATE_TICK;

  // Receive decisions
  // Acceptance is judged at the ninth sample, before it is shifted in
  wire        rx_mid_bit  = os_tick & (os_cnt == 4'(serial_port_pkg::OVERSAMPLE - 1));
  wire        final_async = (rx_state == serial_port_pkg::RX_BITS) & rx_mid_bit & (rx_left == 4'h1);
  wire        rx_accept_a = final_async & (ext_rx | ~ri) & (~filter | rx_sync);
  wire        final_shift = (rx_state == serial_port_pkg::RX_SHIFT0) & shift_tick & (rx_left == 4'h0);
  wire        rx_accept   = rx_accept_a | final_shift;
  wire        ti_set      = tx_busy & tx_tick & (tx_left == 4'h2);
  wire        shift_start = is_shift & rx_enable & ~ri & ~tx_busy
                            & (rx_state == serial_port_pkg::RX_IDLE);
  wire        async_start = ~is_shift & rx_enable & rx_prev & ~rx_sync
                            & (rx_state == serial_port_pkg::RX_IDLE);

  // Flags: software may only clear them and a hardware set wins
  // Writing a 1 to a flag keeps it, so a read-modify-write cannot set one
  always_comb begin
    next_ctl = ctl;
    if (wr_ctl) begin
      next_ctl = PWDATA[7:0];
      next_ctl[serial_port_pkg::CTL_RECEIVE_DONE]  = ri & PWDATA[serial_port_pkg::CTL_RECEIVE_DONE];
      next_ctl[serial_port_pkg::CTL_TRANSMIT_DONE] = ctl[serial_port_pkg::CTL_TRANSMIT_DONE]
                                                    & PWDATA[serial_port_pkg::CTL_TRANSMIT_DONE];
    end
    if (rx_accept_a) begin
      next_ctl[serial_port_pkg::CTL_RX_NINTH] = rx_sync;
    end
    if (rx_accept) begin
      next_ctl[serial_port_pkg::CTL_RECEIVE_DONE] = 1'b1;
    end
    if (ti_set) begin
      next_ctl[serial_port_pkg::CTL_TRANSMIT_DONE] = 1'b1;
    end
  end

  // Shift mode: clock idles high and goes low for the first half of each bit
  assign TXD    = is_shift ? ~((tx_phase | rx_phase) & (shift_div < 4'(serial_port_pkg::SHIFT_MODE_HALF)))
                           : txd_line;
  assign RXD_OE = is_shift & tx_busy;

  // Two flops before any logic reads the receive pin; reset to the idle level

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_meta <= RXD_IN;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rate_ctrl <= serial_port_pkg::RESET_RATE_CTRL;
      ctl       <= serial_port_pkg::RESET_SERIAL_CTL;
      cfg       <= serial_port_pkg::RESET_CONFIG;
      PRDATA    <= 32'h0000_0000;
    end else begin
      ctl <= next_ctl;
      if (wr_rate) begin
        rate_ctrl <= PWDATA[7:0];
      end
      if (wr_cfg) begin
        cfg <= PWDATA[7:0];
      end
      if (setup_cyc) begin
        PRDATA <= {24'h00_0000, rd_mux};
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_buf    <= serial_port_pkg::RESET_SERIAL_BUF;
      overwrite <= 1'b0;
    end else begin
      if (rx_accept) begin
        rx_buf <= rx_shift[8:1];
      end
      // A new overwrite in the same cycle as a buffer read is kept
      if (rx_accept_a & ext_rx & ri) begin
        overwrite <= 1'b1;
      end else if (rd_buf) begin
        overwrite <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      core_cnt  <= 6'h00;
      shift_div <= 4'h0;
      tx_sub    <= 4'h0;
    end else begin
      core_cnt  <= core_cnt + 6'h01;
      shift_div <= shift_tick ? 4'h0 : shift_div + 4'h1;
      if (TX_RATE_TICK) begin
        tx_sub <= tx_sub + 4'h1;
      end
    end
  end

  // A restart truncates the frame in flight; software should wait for the done flag
  // Transmitter: a write restarts it even if a frame is in flight
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_data  <= 8'h00;
      tx_shift <= 11'h7FF;
      tx_left  <= 4'h0;
      tx_busy  <= 1'b0;
      tx_phase <= 1'b0;
      txd_line <= 1'b1;
      RXD_OUT  <= 1'b1;
    end else if (wr_buf) begin
      tx_data  <= PWDATA[7:0];
      tx_busy  <= 1'b1;
      tx_phase <= 1'b0;
      if (is_shift) begin
        tx_shift <= {3'b111, PWDATA[7:0]};
        tx_left  <= serial_port_pkg::TX_LEN_SHIFT;
      end else if (is_8bit) begin
        tx_shift <= {2'b11, PWDATA[7:0], 1'b0};
        tx_left  <= serial_port_pkg::TX_LEN_8BIT;
      end else begin
        tx_shift <= {1'b1, ctl[serial_port_pkg::CTL_TX_NINTH], PWDATA[7:0], 1'b0};
        tx_left  <= serial_port_pkg::TX_LEN_9BIT;
      end
    end else if (tx_busy & tx_tick) begin
      tx_shift <= {1'b1, tx_shift[10:1]};
      tx_left  <= tx_left - 4'h1;
      // The last tick ends the last bit and frees the line
      if (tx_left == 4'h1) begin
        tx_busy  <= 1'b0;
        tx_phase <= 1'b0;
      end else begin
        tx_phase <= 1'b1;
        if (is_shift) begin
          RXD_OUT <= tx_shift[0];
        end else begin
          txd_line <= tx_shift[0];
        end
      end
    end
  end

  // Receiver
  // Mode 0 samples at the clock rise, half a bit after the data moved
  // Async modes wait eight oversample ticks to reach the middle of the start bit
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_state <= serial_port_pkg::RX_IDLE;
      rx_shift <= 9'h000;
      rx_left  <= 4'h0;
      rx_phase <= 1'b0;
      os_cnt   <= 4'h0;
    end else begin
      case (rx_state)
        serial_port_pkg::RX_IDLE: begin
          os_cnt <= 4'h0;
          if (shift_start) begin
            rx_state <= serial_port_pkg::RX_SHIFT0;
            rx_left  <= serial_port_pkg::RX_LEN_SHIFT;
          end else if (async_start) begin
            rx_state <= serial_port_pkg::RX_START;
          end
        end
        serial_port_pkg::RX_START: begin
          if (os_tick) begin
            os_cnt <= os_cnt + 4'h1;
            if (os_cnt == 4'(serial_port_pkg::START_CHECK)) begin
              os_cnt   <= 4'h0;
              rx_left  <= serial_port_pkg::RX_LEN_ASYNC;
              // A glitch that is high again at mid-bit is not a start bit
              rx_state <= rx_sync ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_BITS;
            end
          end
        end
        serial_port_pkg::RX_BITS: begin
          if (os_tick) begin
            os_cnt <= os_cnt + 4'h1;
          end
          if (rx_mid_bit) begin
            rx_shift <= {rx_sync, rx_shift[8:1]};
            rx_left  <= rx_left - 4'h1;
            if (rx_left == 4'h1) begin
              rx_state <= serial_port_pkg::RX_IDLE;
            end
          end
        end
        serial_port_pkg::RX_SHIFT0: begin
          if (shift_tick) begin
            if (rx_left == 4'h0) begin
              rx_phase <= 1'b0;
              rx_state <= serial_port_pkg::RX_IDLE;
            end else begin
              rx_phase <= 1'b1;
            end
          end else if (shift_rise & rx_phase & (rx_left != 4'h0)) begin
            rx_shift <= {rx_sync, rx_shift[8:1]};
            rx_left  <= rx_left - 4'h1;
          end
        end
        default: begin
          rx_state <= serial_port_pkg::RX_IDLE;
        end
      endcase
    end
  end

endmodule : serial_port_four_mode_uart
`default_nettype wire

// [test/serial_port_four_mode_uart_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_port_four_mode_uart_checker (
  input wire logic        CLK,
  input wire logic        RESETN,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [9:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        RXD_OUT,
  input wire logic        RXD_OE,
  input wire logic        TXD
);
  logic [1:0] mode;
  logic       rd;
  logic [9:0] lowrun;
  logic [7:0] oerun;
  wire        wr     = PSEL && PENABLE && PWRITE;
  wire        mapped = PADDR inside {10'h21C, 10'h260, 10'h264, 10'h2BC, 10'h384};
  // Shadow of mode and rate bits, so only ports are needed
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      mode   <= 2'b00;
      rd     <= 1'b0;
      lowrun <= 10'h000;
      oerun  <= 8'h00;
    end else begin
      if (wr && PADDR == 10'h260) mode <= PWDATA[7:6];
      if (wr && PADDR == 10'h21C) rd <= PWDATA[7];
      lowrun <= TXD ? 10'h000 : lowrun + 10'h001;
      oerun  <= RXD_OE ? oerun + 8'h01 : 8'h00;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  property p_oe_mode0; RXD_OE |-> mode == 2'b00; endproperty
  a_oe_mode0: assert property (p_oe_mode0) else $error("data pin driven outside shift mode");
  property p_err; PSEL && PENABLE |-> PREADY && PSLVERR == !mapped; endproperty
  a_err: assert property (p_err) else $error("bus answer wrong");
  property p_shift_low; mode == 2'b00 && $fell(TXD) |-> !TXD[*6] ##1 TXD; endproperty
  a_shift_low: assert property (p_shift_low) else $error("shift clock low phase wrong");
  property p_shift_high; RXD_OE && $rose(TXD) |-> TXD[*6]; endproperty
  a_shift_high: assert property (p_shift_high) else $error("shift clock high phase wrong");
  property p_rxd_stable; RXD_OE && $changed(RXD_OUT) |-> $fell(TXD); endproperty
  a_rxd_stable: assert property (p_rxd_stable) else $error("shift data moved off clock fall");
  property p_tx_start; $rose(RXD_OE) |-> ##[0:12] $fell(TXD); endproperty
  a_tx_start: assert property (p_tx_start) else $error("shift transmit did not start");
  property p_oe_len; $fell(RXD_OE) |-> oerun >= 8'd96 && oerun <= 8'd108; endproperty
  a_oe_len: assert property (p_oe_len) else $error("shift transmit length wrong");
  property p_fixed_rate; mode == 2'b10 && $rose(TXD) |-> (rd ? lowrun[4:0] : lowrun[5:0]) == 6'h00; endproperty
  a_fixed_rate: assert property (p_fixed_rate) else $error("fixed rate bit period wrong");
  c_shift_tx: cover property ($rose(RXD_OE));
  c_fixed: cover property (mode == 2'b10 && $rose(TXD));
  c_err: cover property (PSLVERR);
endmodule : serial_port_four_mode_uart_checker
bind serial_port_four_mode_uart serial_port_four_mode_uart_checker chk_u (.CLK, .RESETN, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PWDATA, .PREADY, .PSLVERR, .RXD_OUT, .RXD_OE, .TXD);
`default_nettype wire

// [test/remote_serial_model.sv]
`timescale 1ns/1ps
`default_nettype none
module remote_serial_model (
  input  wire logic clk,
  input  wire logic txd,
  input  wire logic line,
  output var  logic rxd
);
  initial rxd = 1'b1;
  // Start bit first, data low bit first, stop last; line rests high
  task automatic send(input logic [10:0] bits, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (per) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask : send
  // Centre sampling tolerates the tick phase at the start
  task automatic grab(input int n, input int per, output logic [10:0] bits);
    bits = '0;
    @(negedge txd);
    repeat (per / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd;
      repeat (per) @(posedge clk);
    end
  endtask : grab
  task automatic shift_rd(output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(posedge txd);
      d[i] = line;
    end
  endtask : shift_rd
  task automatic shift_wr(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      rxd <= d[i];
      @(posedge txd);
    end
    rxd <= 1'b1;
  endtask : shift_wr
endmodule : remote_serial_model
`default_nettype wire

// [test/serial_port_four_mode_uart_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_port_four_mode_uart_tb;
  localparam logic [9:0] A_RATE = {serial_port_pkg::IDX_RATE_CTRL, 2'b00};
  localparam logic [9:0] A_CTL  = {serial_port_pkg::IDX_SERIAL_CTL, 2'b00};
  localparam logic [9:0] A_BUF  = {serial_port_pkg::IDX_SERIAL_BUF, 2'b00};
  localparam logic [9:0] A_CFG  = {serial_port_pkg::IDX_CONFIG, 2'b00};
  localparam logic [9:0] A_ST2  = {serial_port_pkg::IDX_SERIAL_CTL2, 2'b00};
  localparam logic [9:0] REGS [5] = '{A_RATE, A_CTL, A_BUF, A_CFG, A_ST2};
  logic        CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, RXD_OUT, RXD_OE, TXD;
  logic        TX_RATE_TICK, RX_RATE_TICK, model_rxd, err_seen, quiet;
  logic [9:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, rdata;
  logic [10:0] frame;
  logic [7:0]  byte_got;
  logic [3:0]  tick_cnt;
  int          err_count, checks_done, cycles;
  wire         line = RXD_OE ? RXD_OUT : model_rxd;
  serial_port_four_mode_uart dut_u (.CLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .TX_RATE_TICK, .RX_RATE_TICK, .RXD_IN(line), .RXD_OUT, .RXD_OE, .TXD);
  remote_serial_model pm_u (.clk(CLK), .txd(TXD), .line(line), .rxd(model_rxd));
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  // Different tick rates per direction: 32-cycle transmit bits, 64-cycle receive bits
  always @(posedge CLK) begin
    tick_cnt     <= tick_cnt + 4'h1;
    TX_RATE_TICK <= tick_cnt[0];
    RX_RATE_TICK <= &tick_cnt[1:0];
    cycles       <= cycles + 1;
    if (cycles == 60000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (err_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d);
    @(posedge CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= {24'h00_0000, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rdata    = PRDATA;
    err_seen = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic wait_ctl(input int b);
    repeat (200) begin
      apb(1'b0, A_CTL, 8'h00);
      if (rdata[b] === 1'b1) break;
    end
  endtask : wait_ctl
  task automatic tx(input logic [7:0] ctl, input logic [7:0] d, input int n, input int per);
    apb(1'b1, A_CTL, ctl);
    fork
      pm_u.grab(n, per, frame);
      apb(1'b1, A_BUF, d);
    join
    chk({21'h00_0000, frame}, {21'h00_0000, n == 10 ? {2'b01, d, 1'b0} : {1'b1, ctl[3], d, 1'b0}});
    apb(1'b0, A_CTL, 8'h00);
    chk(rdata, {24'h00_0000, ctl | 8'h02});
    apb(1'b1, A_CTL, ctl);
  endtask : tx
  task automatic rx(input logic [10:0] bits, input int n, input logic [7:0] ctl, input logic ovw,
                    input logic [7:0] bexp);
    pm_u.send(bits, n, 64);
    apb(1'b0, A_CTL, 8'h00);
    chk(rdata, {24'h00_0000, ctl});
    apb(1'b0, A_ST2, 8'h00);
    chk(rdata, {24'h00_0000, 2'b00, ovw, 5'h00});
    apb(1'b0, A_BUF, 8'h00);
    chk(rdata, {24'h00_0000, bexp});
  endtask : rx
  initial begin
    {PSEL, PENABLE, PWRITE, TX_RATE_TICK, RX_RATE_TICK, RESETN} = 6'h00;
    {PADDR, PWDATA, tick_cnt} = '0;
    repeat (6) @(posedge CLK);
    RESETN <= 1'b1;
    foreach (REGS[i]) begin
      apb(1'b0, REGS[i], 8'h00);
      chk(rdata, 32'h0000_0000);
    end
    apb(1'b0, 10'h004, 8'h00);
    chk({31'h0000_0000, err_seen}, 32'h0000_0001);
    apb(1'b1, A_CTL, 8'h00);
    fork
      pm_u.shift_rd(byte_got);
      apb(1'b1, A_BUF, 8'hA5);
    join
    chk({24'h00_0000, byte_got}, 32'h0000_00A5);
    wait_ctl(1);
    chk(rdata, 32'h0000_0002);
    fork
      pm_u.shift_wr(8'h3C);
      apb(1'b1, A_CTL, 8'h10);
    join
    wait_ctl(0);
    chk(rdata, 32'h0000_0011);
    quiet = 1'b1;
    repeat (30) @(posedge CLK) quiet &= TXD;
    chk({31'h0000_0000, quiet}, 32'h0000_0001);
    apb(1'b0, A_BUF, 8'h00);
    chk(rdata, 32'h0000_003C);
    tx(8'h50, 8'h96, 10, 32);
    rx({2'b01, 8'h5A, 1'b0}, 10, 8'h55, 1'b0, 8'h5A);
    rx({2'b01, 8'h11, 1'b0}, 10, 8'h55, 1'b0, 8'h5A);
    apb(1'b1, A_CTL, 8'h70);
    rx({2'b00, 8'h77, 1'b0}, 10, 8'h70, 1'b0, 8'h5A);
    pm_u.send(11'h000, 1, 4);
    repeat (700) @(posedge CLK);
    rx({2'b01, 8'h66, 1'b0}, 10, 8'h75, 1'b0, 8'h66);
    apb(1'b1, A_CFG, 8'h40);
    rx({2'b01, 8'h33, 1'b0}, 10, 8'h75, 1'b1, 8'h33);
    apb(1'b0, A_ST2, 8'h00);
    chk(rdata, 32'h0000_0000);
    apb(1'b1, A_CFG, 8'h00);
    tx(8'h98, 8'h81, 11, 64);
    apb(1'b1, A_RATE, 8'h80);
    tx(8'h90, 8'h3C, 11, 32);
    apb(1'b1, A_RATE, 8'h00);
    rx({2'b10, 8'hC3, 1'b0}, 11, 8'h91, 1'b0, 8'hC3);
    apb(1'b1, A_CTL, 8'hF0);
    rx({2'b10, 8'h2E, 1'b0}, 11, 8'hF0, 1'b0, 8'hC3);
    rx({2'b11, 8'h4D, 1'b0}, 11, 8'hF5, 1'b0, 8'h4D);
    tx(8'hD8, 8'h6E, 11, 32);
    complete_run();
  end
endmodule : serial_port_four_mode_uart_tb
`default_nettype wire
